/* File: inc/irq_pm_pkg.sv */
// constants, register map and source tables for the interrupt and power-mode block
// assumes a 12-clock machine cycle core and an avalon-mm register master
package irq_pm_pkg;
    localparam int          N_SRC          = 10;
    localparam int          CLKS_PER_MCYC  = 12;
    localparam int          S5P2_PHASE     = 9;
    localparam int          INT_RST_MCYC   = 3;
    localparam int          ADDR_W         = 10;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_PWR        = 8'h87;
    localparam logic [7:0]  IDX_EN2        = 8'ha7;
    localparam logic [7:0]  IDX_EN         = 8'ha8;
    localparam logic [7:0]  IDX_PRI2       = 8'hb7;
    localparam logic [7:0]  IDX_PRI        = 8'hb8;
    localparam logic [7:0]  IDX_STAT       = 8'hc0;
    localparam logic [7:0]  PWR_RST        = 8'h00;
    localparam logic [7:0]  EN_RST         = 8'h00;
    localparam logic [7:0]  EN2_RST        = 8'h00;
    localparam logic [7:0]  PRI_RST        = 8'h00;
    localparam logic [7:0]  PRI2_RST       = 8'h00;
    localparam logic [7:0]  PRI2_USED      = 8'h93;
    localparam int          PWR_HALT       = 0;
    localparam int          PWR_DOWN       = 1;
    localparam int          PWR_TXSEL      = 2;
    localparam int          PWR_RXSEL      = 3;
    localparam int          PWR_ADCEN      = 4;
    localparam int          PWR_UVROFF     = 5;
    localparam int          PWR_DBL2       = 6;
    localparam int          PWR_DBL        = 7;
    localparam int          EN_GLOBAL      = 7;
    // sources in polling order: int0 uart2 t0 i2c int1 ddc t1 usb uart1 t2
    localparam logic [1:0]  SEL_EN         = 2'h0;
    localparam logic [1:0]  SEL_EN2        = 2'h1;
    localparam logic [1:0]  SRC_REG  [N_SRC] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0,
                                                 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};
    localparam logic [2:0]  SRC_BIT  [N_SRC] = '{3'h0, 3'h4, 3'h1, 3'h1, 3'h2,
                                                 3'h7, 3'h3, 3'h0, 3'h4, 3'h5};
    localparam logic [15:0] SRC_VEC  [N_SRC] = '{16'h0003, 16'h004b, 16'h000b,
                                                 16'h0043, 16'h0013, 16'h003b,
                                                 16'h001b, 16'h0033, 16'h0023,
                                                 16'h002b};
endpackage

/* File: src/irq_pm_ctrl.sv */
// interrupt dispatch and power-mode control with an avalon-mm register slave
// assumes core strobes are synchronous to i_mclk and last one clock
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
module irq_pm_ctrl
    import irq_pm_pkg::*;
#(
    parameter int MCYC_CLKS = CLKS_PER_MCYC
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [31:0]       i_writedata,
    output logic [31:0]            o_readdata,
    output logic                   o_waitrequest,
    input  wire logic [N_SRC-1:0]  i_req,
    input  wire logic              i_last_cycle,
    input  wire logic              i_irq_return,
    input  wire logic              i_int_rst,
    input  wire logic [15:0]       i_pc,
    output logic                   o_hw_call,
    output logic [15:0]            o_vector,
    output logic [15:0]            o_push_pc,
    output logic                   o_cpu_halt,
    output logic                   o_osc_stop,
    output logic                   o_periph_run,
    output logic                   o_core_rst,
    output logic                   o_uart_dbl,
    output logic                   o_uart2_dbl,
    output logic                   o_uvr_disable,
    output logic                   o_uvd_on,
    output logic                   o_adc_irq_en,
    output logic                   o_uart2_rx_sel,
    output logic                   o_uart2_tx_sel
);
    // the phase counter is 8 bits and the sample phase must fall inside the cycle
    if (MCYC_CLKS <= S5P2_PHASE + 1 || MCYC_CLKS > 255) begin : g_bad_mcyc
        $error("MCYC_CLKS must exceed the sample phase and fit 8 bits");
    end

    localparam logic [7:0] LAST_PH  = 8'(MCYC_CLKS - 1);
    localparam logic [7:0] SAMP_PH  = 8'(S5P2_PHASE);
    localparam logic [1:0] RST_LEFT = 2'(INT_RST_MCYC);

    // ----------------------------------------------------------------
    // machine cycle timing
    // ----------------------------------------------------------------
    logic [7:0] phase_q;
    logic       pwr_down;
    logic       mc_start;
    logic       mc_samp;
    logic       mc_end;

    // the oscillator is stopped in power-down, so phases freeze there
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_q <= 8'h00;
        end else if (i_int_rst) begin
            phase_q <= 8'h00;
        end else if (!pwr_down) begin
            phase_q <= (phase_q == LAST_PH) ? 8'h00 : phase_q + 8'h01;
        end
    end

    assign mc_start = !pwr_down && phase_q == 8'h00;
    assign mc_samp  = !pwr_down && phase_q == SAMP_PH;
    assign mc_end   = !pwr_down && phase_q == LAST_PH;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] pwr_q;
    logic [7:0] en_q;
    logic [7:0] en2_q;
    logic [7:0] pri_q;
    logic [7:0] pri2_q;
    logic [1:0] inprog_q;
    logic       ack_q;
    logic [7:0] idx;
    logic       wr_go;
    logic       rd_go;
    logic       wake;
    logic       access_q;

    assign idx   = i_address[ADDR_W-1:2];
    assign wr_go = i_write && ack_q;
    assign rd_go = i_read && ack_q;
    assign pwr_down = pwr_q[PWR_DOWN];

    // one wait state: data is prepared in the first cycle, taken in the second
    assign o_waitrequest = (i_read || i_write) && !ack_q;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_read || i_write) && !ack_q;
        end
    end

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] pw,
                                            input logic [7:0] e1, input logic [7:0] e2,
                                            input logic [7:0] p1, input logic [7:0] p2,
                                            input logic [7:0] st);
        unique case (a)
            IDX_PWR:  reg_read = pw;
            IDX_EN:   reg_read = e1;
            IDX_EN2:  reg_read = e2;
            IDX_PRI:  reg_read = p1;
            IDX_PRI2: reg_read = p2;
            IDX_STAT: reg_read = st;
            default:  reg_read = 8'h00;
        endcase
    endfunction

    logic [3:0] last_src_q;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_readdata <= 32'h0000_0000;
        end else if (i_read && !ack_q) begin
            o_readdata <= {24'h000000, reg_read(idx, pwr_q, en_q, en2_q, pri_q, pri2_q,
                                                {last_src_q, inprog_q, pwr_q[1:0]})};
        end
    end

    // internal reset puts every writable register back to its defined state
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pwr_q <= PWR_RST;
        end else if (i_int_rst) begin
            pwr_q <= PWR_RST;
        end else if (wr_go && idx == IDX_PWR) begin
            pwr_q <= i_writedata[7:0];
        end else if (wake) begin
            pwr_q[PWR_HALT] <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en_q   <= EN_RST;
            en2_q  <= EN2_RST;
            pri_q  <= PRI_RST;
            pri2_q <= PRI2_RST;
        end else if (i_int_rst) begin
            en_q   <= EN_RST;
            en2_q  <= EN2_RST;
            pri_q  <= PRI_RST;
            pri2_q <= PRI2_RST;
        end else if (wr_go) begin
            if (idx == IDX_EN) begin
                en_q <= i_writedata[7:0];
            end
            if (idx == IDX_EN2) begin
                en2_q <= i_writedata[7:0];
            end
            if (idx == IDX_PRI) begin
                pri_q <= i_writedata[7:0];
            end
            if (idx == IDX_PRI2) begin
                pri2_q <= i_writedata[7:0] & PRI2_USED;
            end
        end
    end

    // enable/priority access at any phase but the first and last of the machine cycle blocks that cycle's call
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            access_q <= 1'b0;
        end else if (mc_start) begin
            access_q <= 1'b0;
        end else if ((i_read || i_write)
                     && (idx == IDX_EN || idx == IDX_EN2 || idx == IDX_PRI || idx == IDX_PRI2)) begin
            access_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // sampling and polling
    // ----------------------------------------------------------------
    logic [N_SRC-1:0] samp_q;
    logic [N_SRC-1:0] poll_q;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            samp_q <= '0;
            poll_q <= '0;
        end else begin
            if (mc_samp) begin
                samp_q <= i_req;
            end
            if (mc_start) begin
                poll_q <= samp_q;
            end
        end
    end

    function automatic logic bit_of(input logic [1:0] r, input logic [2:0] b,
                                    input logic [7:0] a, input logic [7:0] c);
        bit_of = (r == SEL_EN) ? a[b] : c[b];
    endfunction

    logic [N_SRC-1:0] en_src;
    logic [N_SRC-1:0] hi_src;
    logic [N_SRC-1:0] hi_pend;
    logic [N_SRC-1:0] lo_pend;
    always_comb begin
        for (int i = 0; i < N_SRC; i++) begin
            en_src[i] = bit_of(SRC_REG[i], SRC_BIT[i], en_q, en2_q) && en_q[EN_GLOBAL];
            hi_src[i] = bit_of(SRC_REG[i], SRC_BIT[i], pri_q, pri2_q);
        end
        hi_pend = poll_q & en_src & hi_src;
        lo_pend = poll_q & en_src & ~hi_src;
    end

    // lowest index wins: index order is the polling order
    function automatic logic [3:0] first_set(input logic [N_SRC-1:0] v);
        first_set = 4'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    logic       hi_ok;
    logic       lo_ok;
    logic       take;
    logic       take_hi;
    logic [3:0] pick;

    assign hi_ok   = |hi_pend && !inprog_q[1];
    assign lo_ok   = |lo_pend && inprog_q == 2'b00;
    assign take_hi = hi_ok;
    assign pick    = take_hi ? first_set(hi_pend) : first_set(lo_pend);
    // a halted core sits in its final cycle by definition
    assign take    = mc_end && (hi_ok || lo_ok)
                     && (i_last_cycle || pwr_q[PWR_HALT])
                     && !i_irq_return && !access_q;
    assign wake    = mc_end && |(poll_q & en_src) && pwr_q[PWR_HALT];

    // ----------------------------------------------------------------
    // call generation and level tracking
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hw_call  <= 1'b0;
            o_vector   <= 16'h0000;
            o_push_pc  <= 16'h0000;
            last_src_q <= 4'h0;
        end else begin
            o_hw_call <= take && !i_int_rst;
            if (take) begin
                o_vector   <= SRC_VEC[pick];
                o_push_pc  <= i_pc;
                last_src_q <= pick;
            end
        end
    end

    // a plain return has no strobe here, so the level stays busy after it
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            inprog_q <= 2'b00;
        end else if (i_int_rst) begin
            inprog_q <= 2'b00;
        end else if (take) begin
            inprog_q[take_hi ? 1 : 0] <= 1'b1;
        end else if (i_irq_return) begin
            if (inprog_q[1]) begin
                inprog_q[1] <= 1'b0;
            end else begin
                inprog_q[0] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // internal reset stretch and mode outputs
    // ----------------------------------------------------------------
    logic [1:0] rst_cnt_q;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_cnt_q <= 2'h0;
        end else if (i_int_rst) begin
            rst_cnt_q <= RST_LEFT;
        end else if (mc_end && rst_cnt_q != 2'h0) begin
            rst_cnt_q <= rst_cnt_q - 2'h1;
        end
    end

    // an external reset shorter than two machine cycles is the far end's fault
    assign o_core_rst     = rst_cnt_q != 2'h0;
    assign o_cpu_halt     = pwr_q[PWR_HALT] && !pwr_q[PWR_DOWN];
    assign o_osc_stop     = pwr_q[PWR_DOWN];
    assign o_periph_run   = !pwr_q[PWR_DOWN];
    assign o_uvd_on       = 1'b1;
    assign o_uart_dbl     = pwr_q[PWR_DBL];
    assign o_uart2_dbl    = pwr_q[PWR_DBL2];
    assign o_uvr_disable  = pwr_q[PWR_UVROFF];
    assign o_adc_irq_en   = pwr_q[PWR_ADCEN];
    assign o_uart2_rx_sel = pwr_q[PWR_RXSEL];
    assign o_uart2_tx_sel = pwr_q[PWR_TXSEL];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // every check is gated by the external reset; a mid-run reset restarts them all
    // internal reset is not a disable: the call path must stay legal through it
    chk_call_needs_last: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_hw_call |-> $past(i_last_cycle) || $past(pwr_q[PWR_HALT]))
        else $error("call outside final instruction cycle");
    chk_call_not_return: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_hw_call |-> !$past(i_irq_return))
        else $error("call during return from interrupt");
    chk_call_global_en: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_hw_call |-> $past(en_q[EN_GLOBAL]))
        else $error("call with global enable clear");
    chk_high_blocks_all: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        inprog_q[1] |=> !o_hw_call)
        else $error("call while high level in progress");
    chk_low_blocks_low: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        inprog_q[0] && !(|hi_pend) |=> !o_hw_call)
        else $error("low call while low level in progress");
    chk_call_sets_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && !i_int_rst |=> inprog_q != 2'b00)
        else $error("call did not mark a level");
    chk_call_one_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_hw_call |=> !o_hw_call)
        else $error("call strobe longer than one clock");
    chk_return_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_irq_return && inprog_q[1] && !i_int_rst |=> !inprog_q[1])
        else $error("return did not clear the high level");
    chk_sample_phase: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        mc_samp |=> samp_q == $past(i_req))
        else $error("request flags not captured at the sample phase");
    chk_poll_fresh: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        mc_start |=> poll_q == $past(samp_q))
        else $error("poll did not start from the latest sample");
    chk_pri2_unused: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (pri2_q & ~PRI2_USED) == 8'h00)
        else $error("unused secondary priority bit set");
    chk_global_blocks: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !en_q[EN_GLOBAL] |=> !o_hw_call)
        else $error("call issued with global enable low");
    chk_vector_fixed: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_hw_call |-> o_vector[2:0] == 3'h3 && o_vector[15:7] == 9'h000)
        else $error("vector outside table pattern");
    chk_pc_pushed: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_hw_call |-> o_push_pc == $past(i_pc))
        else $error("pushed pc is not the interrupted pc");
    chk_pd_no_wake: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        pwr_q[PWR_DOWN] && !i_int_rst && !wr_go |=> pwr_q[PWR_DOWN])
        else $error("power-down left without reset");
    chk_pd_no_call: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        pwr_q[PWR_DOWN] |=> !o_hw_call)
        else $error("call issued in power-down");
    chk_pd_stops_phase: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        pwr_q[PWR_DOWN] && $past(pwr_q[PWR_DOWN]) && !$past(i_int_rst) |-> $stable(phase_q))
        else $error("machine cycle ran in power-down");
    chk_idle_wake: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wake && !i_int_rst && !wr_go |=> !pwr_q[PWR_HALT])
        else $error("enabled interrupt did not end idle");
    chk_int_rst_len: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_core_rst) |-> o_core_rst [*8])
        else $error("internal reset stretch too short");
    // precedence is checked on the outputs, where the core actually sees it
    chk_pd_precedence: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        pwr_q[PWR_DOWN] |-> !o_cpu_halt && o_osc_stop && !o_periph_run)
        else $error("power-down did not take precedence");
endmodule

/* File: test/core_model.sv */
// core sequencer model: final-cycle flag, return strobe and a program counter with call stack
// assumes the bench commands every return and stall; single clock domain
`timescale 1ns/1ns
module core_model (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic        i_hw_call,
    input  wire logic [15:0] i_vector,
    input  wire logic [15:0] i_push_pc,
    input  wire logic        i_return_cmd,
    input  wire logic        i_stall,
    output logic             o_last_cycle,
    output logic             o_irq_return,
    output logic [15:0]      o_pc
);
    logic [15:0] stack_q [$];
    // a stalled core sits inside a multi-cycle instruction, so no call may land
    assign o_last_cycle = !i_stall;
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pc   <= 16'h0100;
            o_irq_return <= 1'b0;
            stack_q.delete();
        end else begin
            o_irq_return <= i_return_cmd;
            if (i_hw_call) begin
                stack_q.push_back(i_push_pc);
                o_pc <= i_vector;
            end else if (i_return_cmd && stack_q.size() > 0) begin
                o_pc <= stack_q.pop_back();
            end
        end
    end
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the interrupt dispatch and power-mode block
// assumes core_model.sv and a 10 MHz machine clock
`timescale 1ns/1ns
module tb_top;
    import irq_pm_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam logic [9:0] A_PWR  = 10'h21c;
    localparam logic [9:0] A_EN2  = 10'h29c;
    localparam logic [9:0] A_EN   = 10'h2a0;
    localparam logic [9:0] A_PRI2 = 10'h2dc;
    localparam logic [9:0] A_PRI  = 10'h2e0;
    localparam logic [9:0] A_STAT = 10'h300;
    typedef struct packed {logic [9:0] a; logic [7:0] en; logic [15:0] vec;} row_t;
    localparam row_t ROWS [N_SRC] = '{
        '{10'h2a0, 8'h81, 16'h0003}, '{10'h29c, 8'h10, 16'h004b}, '{10'h2a0, 8'h82, 16'h000b},
        '{10'h29c, 8'h02, 16'h0043}, '{10'h2a0, 8'h84, 16'h0013}, '{10'h29c, 8'h80, 16'h003b},
        '{10'h2a0, 8'h88, 16'h001b}, '{10'h29c, 8'h01, 16'h0033}, '{10'h2a0, 8'h90, 16'h0023},
        '{10'h2a0, 8'ha0, 16'h002b}};
    logic              i_mclk = 1'b0, i_rst_b = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic              i_int_rst = 1'b0, return_cmd = 1'b0, stall = 1'b0;
    logic [9:0]        i_address = 10'h000;
    logic [31:0]       i_writedata = 32'h0;
    logic [N_SRC-1:0]  i_req = 10'h000;
    logic [31:0]       o_readdata;
    logic [15:0]       o_vector, o_push_pc, core_pc, pc_before;
    logic              o_waitrequest, o_hw_call, o_cpu_halt, o_osc_stop, o_periph_run, o_core_rst;
    logic              o_uart_dbl, o_uart2_dbl, o_uvr_disable, o_uvd_on, o_adc_irq_en;
    logic              o_uart2_rx_sel, o_uart2_tx_sel, last_cycle, irq_return;
    logic [7:0]        rd;
    logic              seen;
    int                mismatches = 0, total_checks = 0, call_cnt = 0, n, i;

    irq_pm_ctrl u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_req(i_req),
        .i_last_cycle(last_cycle), .i_irq_return(irq_return), .i_int_rst(i_int_rst),
        .i_pc(core_pc), .o_hw_call(o_hw_call), .o_vector(o_vector), .o_push_pc(o_push_pc),
        .o_cpu_halt(o_cpu_halt), .o_osc_stop(o_osc_stop), .o_periph_run(o_periph_run),
        .o_core_rst(o_core_rst), .o_uart_dbl(o_uart_dbl), .o_uart2_dbl(o_uart2_dbl),
        .o_uvr_disable(o_uvr_disable), .o_uvd_on(o_uvd_on), .o_adc_irq_en(o_adc_irq_en),
        .o_uart2_rx_sel(o_uart2_rx_sel), .o_uart2_tx_sel(o_uart2_tx_sel));
    core_model u_core (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_hw_call(o_hw_call),
        .i_vector(o_vector), .i_push_pc(o_push_pc), .i_return_cmd(return_cmd),
        .i_stall(stall), .o_last_cycle(last_cycle), .o_irq_return(irq_return),
        .o_pc(core_pc));

    always #50 i_mclk = ~i_mclk;
    always @(negedge i_mclk) begin
        if (o_hw_call === 1'b1) begin
            call_cnt++;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic conclude;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        begin
            total_checks++;
            if (got !== exp) begin
                mismatches++;
                $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // request held one edge past the edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd);
        int k;
        begin
            i_address   <= a;
            i_write     <= wr;
            i_read      <= !wr;
            i_writedata <= {24'h0, wd};
            k = 0;
            @(posedge i_mclk);
            while (o_waitrequest !== 1'b0 && k < 50) begin
                @(posedge i_mclk);
                k++;
            end
            if (k >= 50) begin
                mismatches++;
                conclude();
            end
            rd = o_readdata[7:0];
            @(posedge i_mclk);
            i_read  <= 1'b0;
            i_write <= 1'b0;
            @(posedge i_mclk);
        end
    endtask
    task automatic rchk(input string nm, input logic [9:0] a, input logic [7:0] exp);
        begin
            bus(1'b0, a, 8'h00);
            chk(nm, {24'h0, rd}, {24'h0, exp});
        end
    endtask
    task automatic wait_call(input int lim);
        int c0;
        begin
            c0 = call_cnt;
            seen = 1'b0;
            for (int k = 0; k < lim && !seen; k++) begin
                @(posedge i_mclk);
                seen = (call_cnt != c0);
            end
        end
    endtask
    task automatic leave_isr;
        begin
            return_cmd <= 1'b1;
            @(posedge i_mclk);
            return_cmd <= 1'b0;
            @(posedge i_mclk);
        end
    endtask
    task automatic do_reset(input int cyc);
        begin
            i_rst_b <= 1'b0;
            repeat (cyc) @(posedge i_mclk);
            i_rst_b <= 1'b1;
            @(posedge i_mclk);
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        do_reset(4);
        rchk("pwr_rst", A_PWR, 8'h00);
        chk("pd_outs", {o_osc_stop, o_cpu_halt, o_periph_run, o_uvd_on}, 4'b0011);
        rchk("unmapped", 10'h004, 8'h00);
        bus(1'b1, A_PRI2, 8'hff);
        rchk("pri2_bits", A_PRI2, 8'h93);
        bus(1'b1, A_PRI2, 8'h00);
        for (i = 0; i < N_SRC; i++) begin
            bus(1'b1, A_EN, 8'h80);
            bus(1'b1, A_EN2, 8'h00);
            bus(1'b1, ROWS[i].a, ROWS[i].en);
            pc_before = core_pc;
            i_req[i] <= 1'b1;
            wait_call(40);
            chk("call", seen, 1'b1);
            chk("vector", o_vector, ROWS[i].vec);
            chk("push_pc", o_push_pc, pc_before);
            i_req <= 10'h000;
            // let the last held sample drain while the level still blocks it
            repeat (30) @(posedge i_mclk);
            leave_isr();
            bus(1'b0, A_STAT, 8'h00);
            chk("inprog", rd[3:2], 2'b00);
        end
        bus(1'b1, A_EN, 8'hff);
        bus(1'b1, A_EN2, 8'hff);
        i_req <= 10'h3ff;
        wait_call(40);
        chk("first_poll", o_vector, 16'h0003);
        i_req <= 10'h3fe;
        wait_call(40);
        chk("low_blocks_low", seen, 1'b0);
        leave_isr();
        wait_call(40);
        chk("second_poll", o_vector, 16'h004b);
        bus(1'b1, A_PRI, 8'h02);
        wait_call(40);
        chk("preempt", o_vector, 16'h000b);
        chk("nested_push", o_push_pc, 16'h004b);
        bus(1'b1, A_PRI, 8'h06);
        wait_call(40);
        chk("high_no_preempt", seen, 1'b0);
        i_req <= 10'h000;
        repeat (30) @(posedge i_mclk);
        leave_isr();
        leave_isr();
        bus(1'b0, A_STAT, 8'h00);
        chk("both_cleared", rd[3:2], 2'b00);
        bus(1'b1, A_PRI, 8'h00);
        bus(1'b1, A_EN, 8'h7f);
        i_req <= 10'h3ff;
        wait_call(40);
        chk("global_off", seen, 1'b0);
        i_req <= 10'h000;
        bus(1'b1, A_EN, 8'hff);
        stall <= 1'b1;
        i_req <= 10'h001;
        wait_call(40);
        chk("not_last_cycle", seen, 1'b0);
        i_req <= 10'h000;
        repeat (30) @(posedge i_mclk);
        stall <= 1'b0;
        wait_call(40);
        chk("forgotten", seen, 1'b0);
        // keep a register access in every machine cycle so each poll is blocked
        n = call_cnt;
        i_req <= 10'h001;
        repeat (14) bus(1'b1, A_EN, 8'hff);
        chk("reg_access_blocks", call_cnt, n);
        wait_call(40);
        chk("after_access", seen, 1'b1);
        i_req <= 10'h000;
        repeat (30) @(posedge i_mclk);
        leave_isr();
        bus(1'b1, A_PWR, 8'h01);
        chk("idle", o_cpu_halt, 1'b1);
        i_req <= 10'h001;
        wait_call(40);
        chk("idle_wake", {seen, o_cpu_halt}, 2'b10);
        i_req <= 10'h000;
        rchk("idle_clr", A_PWR, 8'h00);
        repeat (30) @(posedge i_mclk);
        leave_isr();
        bus(1'b1, A_PWR, 8'hfc);
        chk("pwr_outs", {o_uart_dbl, o_uart2_dbl, o_uvr_disable, o_adc_irq_en,
            o_uart2_rx_sel, o_uart2_tx_sel}, 6'h3f);
        rchk("pwr_rw", A_PWR, 8'hfc);
        i_int_rst <= 1'b1;
        @(posedge i_mclk);
        i_int_rst <= 1'b0;
        n = 0;
        repeat (60) begin
            @(negedge i_mclk);
            if (o_core_rst === 1'b1) begin
                n++;
            end
        end
        @(posedge i_mclk);
        chk("int_rst_len", (n > 24 && n <= 36), 1'b1);
        rchk("int_rst_pwr", A_PWR, 8'h00);
        bus(1'b1, A_EN, 8'hff);
        bus(1'b1, A_PWR, 8'h03);
        chk("pd_mode", {o_osc_stop, o_cpu_halt, o_periph_run, o_uvd_on}, 4'b1001);
        i_req <= 10'h3ff;
        wait_call(40);
        chk("pd_no_wake", seen, 1'b0);
        i_req <= 10'h000;
        do_reset(24);
        chk("pd_exit", {o_osc_stop, o_periph_run}, 2'b01);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        mismatches++;
        conclude();
    end
endmodule
